// ### design/pdt_pkg.sv
/*
 Constants and types for the dead-time configuration block: register
 offsets, field positions, reset values and the packed state record.
 Assumes a 32-bit classic Wishbone bus and a clock equal to the
 instruction cycle.
*/
// Notes on behaviour
// - Setup bits 15:14 pick unit B's count period as 1, 2, 4 or 8 clock cycles.
// - Setup bits 13:8 hold unit B's unsigned 6-bit dead time in unit B periods.
// - Setup bits 7:6 pick unit A's count period as 1, 2, 4 or 8 clock cycles.
// - Setup bits 5:0 hold unit A's unsigned 6-bit dead time in unit A periods.
package pdt_pkg;
   // Register byte addresses
   localparam logic [3:0] ADDR_SETUP = 4'h0;
   localparam logic [3:0] ADDR_SELECT = 4'h4;
   localparam logic [3:0] ADDR_STATUS = 4'h8;
   // Setup register fields
   localparam int B_PS_LSB = 14;
   localparam int B_CNT_LSB = 8;
   localparam int A_PS_LSB = 6;
   localparam int A_CNT_LSB = 0;
   localparam int SEL_W = 6;
   // Status register fields
   localparam int ST_BUSY_LSB = 0;
   localparam int ST_HI_LSB = 3;
   localparam int ST_LO_LSB = 6;
   // Reset values
   localparam logic [15:0] SETUP_RST = 16'h0000;
   localparam logic [5:0] SELECT_RST = 6'h00;
   localparam int NPAIR = 3;

   // Per-pair dead-time engine state
   typedef struct packed {
      logic prev;       // Last sampled demand level
      logic hi;         // High-side drive
      logic lo;         // Low-side drive
      logic busy;       // Dead time running
      logic tgt;        // Side to enable when done
      logic [1:0] ps;   // Prescale latched at the edge
      logic [5:0] cnt;  // Remaining prescaled periods
      logic [2:0] sub;  // Divider inside one period
   } pdt_pair_t;

   // Whole block state
   typedef struct packed {
      logic [15:0] setup;
      logic [5:0] sel;
      logic ack;
      logic [31:0] dat;
      pdt_pair_t [NPAIR-1:0] pr;
   } pdt_state_t;
endpackage

// ### design/pdt_config.sv
/*
 Dead-time configuration and generation for three complementary PWM
 pairs, with its registers on a classic Wishbone slave.
 Assumes clk is the instruction clock, all inputs are synchronous to it,
 and the demand inputs come from the duty-cycle logic outside.
*/
// Decided for this implementation: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/100ps
module pdt_config (
   input wire logic clk,             // Instruction clock
   input wire logic sys_rst,         // Synchronous reset, high
   input wire logic wb_cyc_i,        // Wishbone cycle
   input wire logic wb_stb_i,        // Wishbone strobe
   input wire logic wb_we_i,         // Write enable
   input wire logic [3:0] wb_adr_i,  // Byte address
   input wire logic [3:0] wb_sel_i,  // Byte lanes
   input wire logic [31:0] wb_dat_i, // Write data
   output logic [31:0] wb_dat_o,     // Read data
   output logic wb_ack_o,            // Acknowledge
   input wire logic [2:0] pwm_in,    // Raw demand per pair
   output logic [2:0] pwm_hi,        // High-side outputs
   output logic [2:0] pwm_lo         // Low-side outputs
);

   pdt_pkg::pdt_state_t s_r;
   pdt_pkg::pdt_state_t s_nxt;

   // Last divider step of a period of 1, 2, 4 or 8 cycles
   function automatic logic [2:0] last_sub(input logic [1:0] ps);
      logic [2:0] p;
      p = 3'h0;
      unique case (ps)
         2'h0: p = 3'h0;
         2'h1: p = 3'h1;
         2'h2: p = 3'h3;
         2'h3: p = 3'h7;
      endcase
      return p;
   endfunction

   // Field views of the setup register
   logic [1:0] b_ps;
   logic [5:0] b_cnt;
   logic [1:0] a_ps;
   logic [5:0] a_cnt;
   logic acc;
   logic wr;
   logic [15:0] setup_w;
   logic [31:0] rd;
   logic [2:0] busy_v;
   logic [2:0] hi_v;
   logic [2:0] lo_v;

   assign b_ps = s_r.setup[pdt_pkg::B_PS_LSB +: 2];
   assign b_cnt = s_r.setup[pdt_pkg::B_CNT_LSB +: 6];
   assign a_ps = s_r.setup[pdt_pkg::A_PS_LSB +: 2];
   assign a_cnt = s_r.setup[pdt_pkg::A_CNT_LSB +: 6];

   // Bus qualifiers; write lands on the edge where ack is seen
   assign acc = wb_cyc_i & wb_stb_i;
   assign wr = acc & wb_we_i & s_r.ack;

   // Byte-lane merge for the 16-bit setup register
   always_comb begin
      setup_w = s_r.setup;
      if (wb_sel_i[0]) begin
         setup_w[7:0] = wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
         setup_w[15:8] = wb_dat_i[15:8];
      end
   end

   // Flattened pair status for readback
   always_comb begin
      for (int i = 0; i < pdt_pkg::NPAIR; i++) begin
         busy_v[i] = s_r.pr[i].busy;
         hi_v[i] = s_r.pr[i].hi;
         lo_v[i] = s_r.pr[i].lo;
      end
   end

   // Read mux; unmapped addresses answer zero
   always_comb begin
      rd = 32'h0000_0000;
      unique case (wb_adr_i)
         pdt_pkg::ADDR_SETUP: rd[15:0] = s_r.setup;
         pdt_pkg::ADDR_SELECT: rd[pdt_pkg::SEL_W-1:0] = s_r.sel;
         pdt_pkg::ADDR_STATUS: begin
            rd[pdt_pkg::ST_BUSY_LSB +: 3] = busy_v;
            rd[pdt_pkg::ST_HI_LSB +: 3] = hi_v;
            rd[pdt_pkg::ST_LO_LSB +: 3] = lo_v;
         end
         default: rd = 32'h0000_0000;
      endcase
   end

   // Next-state logic for the bus slave and every pair engine
   always_comb begin
      logic use_b;
      use_b = 1'b0;
      s_nxt = s_r;
      // One-cycle ack, dropped the cycle after it is given
      s_nxt.ack = acc & ~s_r.ack;
      if (acc & ~s_r.ack & ~wb_we_i) begin
         s_nxt.dat = rd;
      end
      if (wr && wb_adr_i == pdt_pkg::ADDR_SETUP) begin
         s_nxt.setup = setup_w;
      end
      if (wr && wb_adr_i == pdt_pkg::ADDR_SELECT && wb_sel_i[0]) begin
         s_nxt.sel = wb_dat_i[pdt_pkg::SEL_W-1:0];
      end
      for (int i = 0; i < pdt_pkg::NPAIR; i++) begin
         if (pwm_in[i] != s_r.pr[i].prev) begin
            // Both sides off at once; the new side waits out the dead time
            use_b = pwm_in[i] ? s_r.sel[2*i+1] : s_r.sel[2*i];
            s_nxt.pr[i].prev = pwm_in[i];
            s_nxt.pr[i].hi = 1'b0;
            s_nxt.pr[i].lo = 1'b0;
            s_nxt.pr[i].busy = 1'b1;
            s_nxt.pr[i].tgt = pwm_in[i];
            s_nxt.pr[i].sub = 3'h0;
            // Latching prescale and count keeps a mid-delay write harmless
            s_nxt.pr[i].ps = use_b ? b_ps : a_ps;
            s_nxt.pr[i].cnt = use_b ? b_cnt : a_cnt;
         end else if (s_r.pr[i].busy) begin
            if (s_r.pr[i].cnt == 6'h00) begin
               s_nxt.pr[i].busy = 1'b0;
               s_nxt.pr[i].hi = s_r.pr[i].tgt;
               s_nxt.pr[i].lo = ~s_r.pr[i].tgt;
            end else if (s_r.pr[i].sub == last_sub(s_r.pr[i].ps)) begin
               // One prescaled period elapsed
               s_nxt.pr[i].sub = 3'h0;
               s_nxt.pr[i].cnt = s_r.pr[i].cnt - 6'h01;
            end else begin
               s_nxt.pr[i].sub = s_r.pr[i].sub + 3'h1;
            end
         end
      end
   end

   // State register; pairs idle with both sides off until first demand edge
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         s_r <= '0;
         s_r.setup <= pdt_pkg::SETUP_RST;
         s_r.sel <= pdt_pkg::SELECT_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Outputs straight from flops
   assign wb_ack_o = s_r.ack;
   assign wb_dat_o = s_r.dat;
   assign pwm_hi = hi_v;
   assign pwm_lo = lo_v;

   // Select register upper bits always read back as zero
   sel_upper_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
      (acc && !s_r.ack && !wb_we_i && wb_adr_i == pdt_pkg::ADDR_SELECT)
      |=> (wb_ack_o && wb_dat_o[31:6] == 26'h0 && wb_dat_o[5:0] == s_r.sel))
      else $error("select readback upper bits not zero");

   for (genvar g = 0; g < pdt_pkg::NPAIR; g++) begin : g_chk
      // Chosen unit follows the select bit of the edge direction
      unit_pick_a: assert property (@(posedge clk) disable iff (sys_rst)
         (pwm_in[g] != s_r.pr[g].prev)
         |=> (s_r.pr[g].cnt == ((s_r.pr[g].tgt ? $past(s_r.sel[2*g+1]) : $past(s_r.sel[2*g]))
             ? $past(b_cnt) : $past(a_cnt))))
         else $error("dead time loaded from wrong unit");

      // Unit B prescale loaded on a B-sourced edge
      b_prescale_load_a: assert property (@(posedge clk) disable iff (sys_rst)
         (pwm_in[g] && !s_r.pr[g].prev && s_r.sel[2*g+1]) |=> (s_r.pr[g].ps == $past(b_ps)))
         else $error("unit B prescale not latched");

      // Unit A prescale loaded on an A-sourced edge
      a_prescale_load_a: assert property (@(posedge clk) disable iff (sys_rst)
         (!pwm_in[g] && s_r.pr[g].prev && !s_r.sel[2*g]) |=> (s_r.pr[g].ps == $past(a_ps)))
         else $error("unit A prescale not latched");

      // Divider never runs past the prescaled period
      period_bound_a: assert property (@(posedge clk) disable iff (sys_rst)
         s_r.pr[g].busy |-> (s_r.pr[g].sub <= last_sub(s_r.pr[g].ps)))
         else $error("prescale divider exceeded period");

      // Count steps down only at the end of a period
      count_step_a: assert property (@(posedge clk) disable iff (sys_rst)
         (s_r.pr[g].busy && pwm_in[g] == s_r.pr[g].prev && s_r.pr[g].cnt != 6'h00)
         |=> (s_r.pr[g].cnt == $past(s_r.pr[g].cnt) - (($past(s_r.pr[g].sub)
             == last_sub($past(s_r.pr[g].ps))) ? 6'h01 : 6'h00)))
         else $error("dead-time count stepped off period");

      // Zero dead time with period one drives the new side two edges on
      zero_delay_a: assert property (@(posedge clk) disable iff (sys_rst)
         (pwm_in[g] != s_r.pr[g].prev && a_cnt == 6'h00 && b_cnt == 6'h00)
         ##1 (pwm_in[g] == s_r.pr[g].prev)
         |=> (pwm_hi[g] == s_r.pr[g].prev && pwm_lo[g] == !s_r.pr[g].prev))
         else $error("zero dead time not honoured");

      // Both sides are never driven together
      no_overlap_a: assert property (@(posedge clk) disable iff (sys_rst)
         !(pwm_hi[g] && pwm_lo[g]))
         else $error("high and low sides overlap");
   end

endmodule

// ### testbench/pdt_config_tb.sv
/*
 Self-checking bench for the dead-time configuration block.
 Assumes one clock at 125 MHz and a classic Wishbone master driven here.
*/
`timescale 1ns/100ps
module pdt_config_tb;
   logic clk, sys_rst, cyc, stb, we;
   logic [3:0] adr, sel;
   logic [31:0] dat_i, dat_o, rd;
   logic ack;
   logic [2:0] pwm_in, hi, lo;
   int fail_count = 0, checks = 0, cyc_cnt = 0, n;
   typedef struct {
      logic [15:0] setup;
      logic [5:0] srcs;
      int pair;
      logic dir;
      int cycles;
   } pdt_row_t;
   pdt_row_t rows [10];

   pdt_config i_pdt_config (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_i), .wb_dat_o(dat_o),
      .wb_ack_o(ack), .pwm_in(pwm_in), .pwm_hi(hi), .pwm_lo(lo));

   // Clock and hang guard
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc_cnt++;
      if (cyc_cnt == 30000) begin
         fail_count++;
         wrap_up();
      end
   end

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // One classic cycle; the request holds until ack is sampled high
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q);
      int t;
      t = 0;
      @(posedge clk);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat_i <= d; sel <= 4'hf;
      do begin
         @(posedge clk);
         t++;
      end while (ack !== 1'b1 && t < 50);
      q = dat_o;
      chk("ack", 1, ack);
      cyc <= 1'b0; stb <= 1'b0;
   endtask

   // Edges from the driving edge until the new side turns on
   task automatic measure(input int p, input logic lvl, output int cnt);
      logic ovl;
      ovl = 1'b0;
      cnt = 0;
      @(posedge clk);
      pwm_in[p] <= lvl;
      do begin
         @(posedge clk);
         #1;
         cnt++;
         if ((lvl ? hi[p] : lo[p]) !== 1'b1 && (hi[p] | lo[p]) !== 1'b0) ovl = 1'b1;
      end while ((lvl ? hi[p] : lo[p]) !== 1'b1 && cnt < 600);
      chk("overlap", 0, ovl);
      chk("sides", {30'h0, lvl, !lvl}, {30'h0, hi[p], lo[p]});
   endtask

   task automatic wrap_up();
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // Rows: setup, source bits, pair, direction, edges to the new side (N*P+2)
   initial begin
      rows = '{'{16'h2003, 6'h00, 0, 1'b1, 5}, '{16'h0045, 6'h00, 0, 1'b0, 12},
               '{16'h0082, 6'h00, 1, 1'b1, 10}, '{16'h00c1, 6'h00, 2, 1'b0, 10},
               '{16'h0401, 6'h02, 0, 1'b1, 6}, '{16'h4601, 6'h01, 0, 1'b0, 14},
               '{16'h8301, 6'h08, 1, 1'b1, 14}, '{16'hff01, 6'h10, 2, 1'b0, 506},
               '{16'h0000, 6'h00, 1, 1'b0, 2}, '{16'h0a3f, 6'h20, 2, 1'b1, 12}};
      sys_rst = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 4'h0; sel = 4'h0;
      dat_i = 32'h0; pwm_in = 3'h0;
      repeat (8) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      chk("idle_out", 0, {hi, lo});
      wb(1'b0, pdt_pkg::ADDR_SETUP, 32'h0, rd);
      chk("setup_rst", {16'h0000, pdt_pkg::SETUP_RST}, rd);
      wb(1'b0, pdt_pkg::ADDR_SELECT, 32'h0, rd);
      chk("select_rst", 32'h0, rd);
      foreach (rows[i]) begin
         if (pwm_in[rows[i].pair] === rows[i].dir) measure(rows[i].pair, !rows[i].dir, n);
         wb(1'b1, pdt_pkg::ADDR_SETUP, {16'h0000, rows[i].setup}, rd);
         wb(1'b1, pdt_pkg::ADDR_SELECT, {26'h0, rows[i].srcs}, rd);
         wb(1'b0, pdt_pkg::ADDR_SETUP, 32'h0, rd);
         chk("setup", {16'h0000, rows[i].setup}, rd);
         wb(1'b0, pdt_pkg::ADDR_SELECT, 32'h0, rd);
         chk("select", {26'h0, rows[i].srcs}, rd);
         measure(rows[i].pair, rows[i].dir, n);
         chk("delay", rows[i].cycles, n);
      end
      // Unused select bits stay zero whatever is written
      wb(1'b1, pdt_pkg::ADDR_SELECT, 32'hffff_ffff, rd);
      wb(1'b0, pdt_pkg::ADDR_SELECT, 32'h0, rd);
      chk("select_hi", 32'h0000_003f, rd);
      // Unmapped place reads zero and leaves setup alone
      wb(1'b1, 4'hc, 32'h1234_5678, rd);
      wb(1'b0, 4'hc, 32'h0, rd);
      chk("unmapped", 32'h0, rd);
      wb(1'b0, pdt_pkg::ADDR_SETUP, 32'h0, rd);
      chk("setup_kept", 32'h0000_0a3f, rd);
      // Status: all idle, pair 3 high side on, pairs 1 and 2 low side on
      wb(1'b0, pdt_pkg::ADDR_STATUS, 32'h0, rd);
      chk("status", 32'h0000_00e0, rd);
      wrap_up();
   end
endmodule
